// *** src/ftcc_top.sv ***
`timescale 1ns/10ps
`include "ftcc_regs.svh"

module ftcc_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Fast peripheral clock, sampled as a plain input
  input wire logic fast_peripheral_clock,
  // Compare output pins
  output logic match_a_pin,
  output logic match_a_pin_oe,
  output logic match_b_pin,
  output logic match_b_pin_oe
);
  ftcc_pkg::ftcc_state_t q;
  ftcc_pkg::ftcc_state_t d;

  // ****************************************************************
  // Register read mux
  // ****************************************************************

  // Unmapped offsets and write-only or self-clearing bits read as zero.
  function automatic logic [7:0] rd_mux(input ftcc_pkg::ftcc_state_t s,
                                        input logic [7:0] a);
    logic [7:0] r;
    r = `FTCC_RESET_BYTE;
    unique case (a)
      `FTCC_OFF_GEN_CTRL: begin
        r[`FTCC_GC_PWM_B] = s.pwm_b_enable;
        r[`FTCC_GC_MODE_B_HI:`FTCC_GC_MODE_B_LO] = s.mode_b;
      end
      `FTCC_OFF_TIMER_CTRL: begin
        r[`FTCC_TC_CLEAR_TOP] = s.clear_on_top_match;
        r[`FTCC_TC_PWM_A] = s.pwm_a_enable;
        r[`FTCC_TC_MODE_A_HI:`FTCC_TC_MODE_A_LO] = s.mode_a;
        r[`FTCC_TC_CS_HI:`FTCC_TC_CS_LO] = s.clock_select_field;
      end
      `FTCC_OFF_COUNTER: r = s.counter_value;
      `FTCC_OFF_CMP_A: r = s.compare_a_value;
      `FTCC_OFF_CMP_B: r = s.compare_b_value;
      `FTCC_OFF_TOP: r = s.top_compare_value;
      `FTCC_OFF_FLAGS: begin
        r[`FTCC_FL_MATCH_A] = s.match_a_flag;
        r[`FTCC_FL_MATCH_B] = s.match_b_flag;
        r[`FTCC_FL_OVERFLOW] = s.overflow_flag;
      end
      `FTCC_OFF_CLK_PORT: begin
        r[`FTCC_CP_FAST_SEL] = s.fast_clock_select;
        r[`FTCC_CP_DIR_B] = s.dir_b;
        r[`FTCC_CP_DIR_A] = s.dir_a;
      end
      default: r = `FTCC_RESET_BYTE;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Counter events
  // ****************************************************************

  logic pwm_any;
  logic fast_rise;
  logic src_tick;
  logic count_tick;
  logic top_hit;
  logic top_clear;
  logic hit_a;
  logic hit_b;
  logic wrap;
  logic wr_data_phase;

  assign pwm_any = q.pwm_a_enable | q.pwm_b_enable;

  // A fast-clock rising edge counts only once stages two and three agree.
  assign fast_rise = (q.fck_s2 == q.fck_s3) && q.fck_s3 && !q.fck_lvl;

  assign src_tick = q.fast_clock_select ? fast_rise : 1'b1;

  assign top_hit = q.counted && (q.counter_value == q.top_compare_value);
  assign hit_a = q.counted && (q.counter_value == q.compare_a_value);
  assign hit_b = q.counted && (q.counter_value == q.compare_b_value);

  assign top_clear = top_hit && (q.clear_on_top_match || pwm_any);

  assign wrap = count_tick && (q.counter_value == `FTCC_CNT_MAX) && !pwm_any;

  assign wr_data_phase = q.a_valid && q.a_write;

  // ****************************************************************
  // Prescaler and compare channels
  // ****************************************************************

  ftcc_prescaler u_prescaler (
    .mclk(mclk),
    .rstn(rstn),
    .src_tick(src_tick),
    .pre_clear(q.prescaler_reset),
    .clock_select_field(q.clock_select_field),
    .count_tick(count_tick)
  );

  ftcc_pkg::ftcc_chan_cfg_t ch_cfg [2];
  ftcc_pkg::ftcc_chan_evt_t ch_evt [2];
  logic [1:0] ch_pin;
  logic [1:0] ch_oe;

  // Index 0 is channel A, index 1 is channel B.
  assign ch_cfg[0] = '{pwm_en: q.pwm_a_enable, mode: q.mode_a, dir_out: q.dir_a};
  assign ch_cfg[1] = '{pwm_en: q.pwm_b_enable, mode: q.mode_b, dir_out: q.dir_b};
  assign ch_evt[0] = '{match: hit_a, force_hit: q.force_match_a, top_hit: top_hit};
  assign ch_evt[1] = '{match: hit_b, force_hit: q.force_match_b, top_hit: top_hit};

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc = gc + 1) begin : g_chan
      ftcc_channel u_channel (
        .mclk(mclk),
        .rstn(rstn),
        .cfg(ch_cfg[gc]),
        .evt(ch_evt[gc]),
        .pin(ch_pin[gc]),
        .pin_oe(ch_oe[gc])
      );
    end
  endgenerate

  assign match_a_pin = ch_pin[0];
  assign match_a_pin_oe = ch_oe[0];
  assign match_b_pin = ch_pin[1];
  assign match_b_pin_oe = ch_oe[1];

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb begin
    d = q;
    d.force_match_a = 1'b0;
    d.force_match_b = 1'b0;
    d.prescaler_reset = 1'b0;
    d.counted = 1'b0;

    // Three-stage sampler; stage one feeds stage two and nothing else.
    d.fck_s1 = fast_peripheral_clock;
    d.fck_s2 = q.fck_s1;
    d.fck_s3 = q.fck_s2;
    if (q.fck_s2 == q.fck_s3) begin
      d.fck_lvl = q.fck_s3;
    end

    // Address phase; the slave never stalls, so every request is taken.
    d.a_valid = hsel && htrans[1] && hready;
    d.a_write = hwrite && (hsize == `FTCC_HSIZE_WORD);
    d.a_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      d.rdata = {24'h000000, rd_mux(q, haddr[7:0])};
    end

    if (q.wr_wait != 2'h0) begin
      d.wr_wait = q.wr_wait - 2'h1;
    end

    // counter update; a pending write wins over clear and count.
    if (q.wr_wait == 2'h1) begin
      d.counter_value = q.wr_data;
    end else if (top_clear) begin
      d.counter_value = 8'h00;
    end else if (count_tick) begin
      d.counter_value = q.counter_value + 8'h01;
      d.counted = 1'b1;
    end

    d.ev_a = hit_a;
    d.ev_b = hit_b;
    d.ev_ovf = wrap || (pwm_any && top_hit);

    // Register writes in the data phase.
    if (wr_data_phase) begin
      unique case (q.a_addr)
        `FTCC_OFF_GEN_CTRL: begin
          d.pwm_b_enable = hwdata[`FTCC_GC_PWM_B];
          d.mode_b = ftcc_pkg::ftcc_out_mode_t'(
                     hwdata[`FTCC_GC_MODE_B_HI:`FTCC_GC_MODE_B_LO]);
          d.force_match_b = hwdata[`FTCC_GC_FORCE_B] && !hwdata[`FTCC_GC_PWM_B];
          d.force_match_a = hwdata[`FTCC_GC_FORCE_A] && !q.pwm_a_enable;
          d.prescaler_reset = hwdata[`FTCC_GC_PRE_RST];
        end
        `FTCC_OFF_TIMER_CTRL: begin
          d.clear_on_top_match = hwdata[`FTCC_TC_CLEAR_TOP];
          d.pwm_a_enable = hwdata[`FTCC_TC_PWM_A];
          d.mode_a = ftcc_pkg::ftcc_out_mode_t'(
                     hwdata[`FTCC_TC_MODE_A_HI:`FTCC_TC_MODE_A_LO]);
          d.clock_select_field = hwdata[`FTCC_TC_CS_HI:`FTCC_TC_CS_LO];
        end
        `FTCC_OFF_COUNTER: begin
          d.wr_data = hwdata[7:0];
          d.wr_wait = q.fast_clock_select ? `FTCC_WR_ASYNC_CYC : `FTCC_WR_SYNC_CYC;
        end
        `FTCC_OFF_CMP_A: d.compare_a_value = hwdata[7:0];
        `FTCC_OFF_CMP_B: d.compare_b_value = hwdata[7:0];
        `FTCC_OFF_TOP: d.top_compare_value = hwdata[7:0];
        `FTCC_OFF_FLAGS: begin
          if (hwdata[`FTCC_FL_MATCH_A]) begin
            d.match_a_flag = 1'b0;
          end
          if (hwdata[`FTCC_FL_MATCH_B]) begin
            d.match_b_flag = 1'b0;
          end
          if (hwdata[`FTCC_FL_OVERFLOW]) begin
            d.overflow_flag = 1'b0;
          end
        end
        `FTCC_OFF_CLK_PORT: begin
          d.fast_clock_select = hwdata[`FTCC_CP_FAST_SEL];
          d.dir_b = hwdata[`FTCC_CP_DIR_B];
          d.dir_a = hwdata[`FTCC_CP_DIR_A];
        end
        default: d.a_valid = q.a_valid && d.a_valid;
      endcase
    end

    if (q.ev_a) begin
      d.match_a_flag = 1'b1;
    end
    if (q.ev_b) begin
      d.match_b_flag = 1'b1;
    end
    if (q.ev_ovf) begin
      d.overflow_flag = 1'b1;
    end
  end

  // Reset clears every control register and the counter.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************

  // Zero wait states and an OKAY response keep the slave simple.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
endmodule

// *** common/ftcc_regs.svh ***
`ifndef FTCC_REGS_SVH
`define FTCC_REGS_SVH

// ****************************************************************
// Register byte offsets on the register bus (low address byte).
// ****************************************************************
`define FTCC_OFF_GEN_CTRL 8'h2C
`define FTCC_OFF_TIMER_CTRL 8'h30
`define FTCC_OFF_COUNTER 8'h34
`define FTCC_OFF_CMP_A 8'h38
`define FTCC_OFF_CMP_B 8'h3C
`define FTCC_OFF_TOP 8'h40
`define FTCC_OFF_FLAGS 8'h44
`define FTCC_OFF_CLK_PORT 8'h48

// ****************************************************************
// Field positions.
// ****************************************************************
`define FTCC_GC_PWM_B 6
`define FTCC_GC_MODE_B_HI 5
`define FTCC_GC_MODE_B_LO 4
`define FTCC_GC_FORCE_B 3
`define FTCC_GC_FORCE_A 2
`define FTCC_GC_PRE_RST 1
`define FTCC_TC_CLEAR_TOP 7
`define FTCC_TC_PWM_A 6
`define FTCC_TC_MODE_A_HI 5
`define FTCC_TC_MODE_A_LO 4
`define FTCC_TC_CS_HI 3
`define FTCC_TC_CS_LO 0
`define FTCC_FL_MATCH_A 6
`define FTCC_FL_MATCH_B 5
`define FTCC_FL_OVERFLOW 2
`define FTCC_CP_FAST_SEL 2
`define FTCC_CP_DIR_B 1
`define FTCC_CP_DIR_A 0

// ****************************************************************
// Reset values, widths and timing counts.
// ****************************************************************
`define FTCC_RESET_BYTE 8'h00
`define FTCC_CNT_MAX 8'hFF
`define FTCC_HSIZE_WORD 3'b010
`define FTCC_PRE_BITS 14
`define FTCC_CS_CODES 15
// Counter write latency in tenths of a CPU cycle, as specified.
`define FTCC_WR_SYNC_X10 15
`define FTCC_WR_ASYNC_X10 10
// Least time rounds up, longest time rounds down.
`define FTCC_WR_SYNC_CYC 2'((`FTCC_WR_SYNC_X10 + 9) / 10)
`define FTCC_WR_ASYNC_CYC 2'(`FTCC_WR_ASYNC_X10 / 10)

`endif

// *** common/ftcc_pkg.sv ***
package ftcc_pkg;
  `include "ftcc_regs.svh"

  // Normal-mode pin action on a match.
  typedef enum logic [1:0] {
    FTCC_OM_OFF = 2'b00,
    FTCC_OM_TOGGLE = 2'b01,
    FTCC_OM_CLEAR = 2'b10,
    FTCC_OM_SET = 2'b11
  } ftcc_out_mode_t;

  // Per-channel configuration.
  typedef struct packed {
    logic pwm_en;
    ftcc_out_mode_t mode;
    logic dir_out;
  } ftcc_chan_cfg_t;

  // Per-channel events, each a one-cycle pulse.
  typedef struct packed {
    logic match;
    logic force_hit;
    logic top_hit;
  } ftcc_chan_evt_t;

  typedef struct packed {
    logic pin;
  } ftcc_chan_state_t;

  typedef struct packed {
    logic [`FTCC_PRE_BITS-1:0] div;
  } ftcc_pre_state_t;

  // Whole state of the top block.
  typedef struct packed {
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] rdata;
    logic clear_on_top_match;
    logic pwm_a_enable;
    ftcc_out_mode_t mode_a;
    logic [3:0] clock_select_field;
    logic pwm_b_enable;
    ftcc_out_mode_t mode_b;
    logic [7:0] counter_value;
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic [7:0] top_compare_value;
    logic match_a_flag;
    logic match_b_flag;
    logic overflow_flag;
    logic fast_clock_select;
    logic dir_a;
    logic dir_b;
    logic force_match_a;
    logic force_match_b;
    logic prescaler_reset;
    logic [1:0] wr_wait;
    logic [7:0] wr_data;
    logic counted;
    logic ev_a;
    logic ev_b;
    logic ev_ovf;
    logic fck_s1;
    logic fck_s2;
    logic fck_s3;
    logic fck_lvl;
  } ftcc_state_t;
endpackage

// *** src/ftcc_prescaler.sv ***
`timescale 1ns/10ps
`include "ftcc_regs.svh"

// Free-running divider of the selected source with a tap per clock select code.
module ftcc_prescaler (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic src_tick,
  input wire logic pre_clear,
  input wire logic [3:0] clock_select_field,
  // Counter enable
  output logic count_tick
);
  ftcc_pkg::ftcc_pre_state_t q;
  ftcc_pkg::ftcc_pre_state_t d;
  logic [`FTCC_CS_CODES-1:0] tap;

  // Code n fires on every 2^(n-1)-th source tick.
  genvar gi;
  generate
    for (gi = 0; gi < `FTCC_CS_CODES; gi = gi + 1) begin : g_tap
      if (gi == 0) begin : g_first
        assign tap[gi] = 1'b1;
      end else begin : g_rest
        assign tap[gi] = &q.div[gi-1:0];
      end
    end
  endgenerate

  assign count_tick = (clock_select_field != 4'h0) && src_tick &&
                      tap[4'(clock_select_field - 4'h1)];

  // The divider only moves on source ticks; a reset restarts the phase.
  always_comb begin
    d = q;
    if (pre_clear) begin
      d.div = '0;
    end else if (src_tick) begin
      d.div = q.div + `FTCC_PRE_BITS'(1);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// *** src/ftcc_channel.sv ***
`timescale 1ns/10ps

// One compare output pin with its match action.
module ftcc_channel (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Configuration and events
  input wire ftcc_pkg::ftcc_chan_cfg_t cfg,
  input wire ftcc_pkg::ftcc_chan_evt_t evt,
  // Pin
  output logic pin,
  output logic pin_oe
);
  ftcc_pkg::ftcc_chan_state_t q;
  ftcc_pkg::ftcc_chan_state_t d;
  logic hit;

  assign hit = evt.match | evt.force_hit;

  always_comb begin
    d = q;
    if (cfg.pwm_en) begin
      // Simple PWM: high from the top restart, low after the channel match.
      if (evt.top_hit) begin
        d.pin = 1'b1;
      end else if (evt.match) begin
        d.pin = 1'b0;
      end
    end else if (hit) begin
      unique case (cfg.mode)
        ftcc_pkg::FTCC_OM_OFF: d.pin = q.pin;
        ftcc_pkg::FTCC_OM_TOGGLE: d.pin = ~q.pin;
        ftcc_pkg::FTCC_OM_CLEAR: d.pin = 1'b0;
        ftcc_pkg::FTCC_OM_SET: d.pin = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin = q.pin;
  assign pin_oe = cfg.dir_out && (cfg.mode != ftcc_pkg::FTCC_OM_OFF);
endmodule

// *** test/ftcc_properties.sv ***
`timescale 1ns/10ps
`include "ftcc_regs.svh"

// ****************************************************************
// Port checker for the timer control block.
// ****************************************************************
module ftcc_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Pins
  input wire logic fast_peripheral_clock,
  input wire logic match_a_pin,
  input wire logic match_a_pin_oe,
  input wire logic match_b_pin,
  input wire logic match_b_pin_oe
);
  logic dp_wr_q;
  logic dp_rd_q;
  logic wr2_q;
  logic [7:0] dp_a_q;
  logic gc_w;
  logic bad_a;

  // Data phase tracker; the address is kept so hwdata can be judged later.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
      wr2_q <= 1'b0;
      dp_a_q <= 8'h00;
    end else begin
      dp_wr_q <= hsel && htrans[1] && hready && hwrite && (hsize == 3'h2);
      dp_rd_q <= hsel && htrans[1] && hready && !hwrite;
      dp_a_q <= haddr[7:0];
      wr2_q <= dp_wr_q;
    end
  end

  // Data phases of interest; misaligned or outside offsets are unmapped.
  assign gc_w = dp_wr_q && (dp_a_q == `FTCC_OFF_GEN_CTRL);
  assign bad_a = (dp_a_q[1:0] != 2'h0) || (dp_a_q < 8'h2C) || (dp_a_q > 8'h48);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // A forced channel B action carrying a fresh mode with PWM off.
  sequence force_b(logic [1:0] m);
    gc_w && hwdata[3] && !hwdata[6] && (hwdata[5:4] == m);
  endsequence

  a_bus_always_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_rdata_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_rdata_holds: assert property ($changed(hrdata) |-> dp_rd_q)
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (dp_rd_q && bad_a |-> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_gc_bits_zero: assert property (dp_rd_q && (dp_a_q == 8'h2C) |-> hrdata[3:1] == 3'h0)
    else $error("force or prescaler bit read as one");
  a_force_b_set: assert property (force_b(2'h3) |-> ##2 match_b_pin)
    else $error("forced set left pin b low");
  a_force_b_clear: assert property (force_b(2'h2) |-> ##2 !match_b_pin)
    else $error("forced clear left pin b high");
  a_b_disconnect: assert property (gc_w && (hwdata[5:4] == 2'h0) |=> !match_b_pin_oe)
    else $error("pin b driven with mode off");
  a_a_disconnect: assert property (dp_wr_q && (dp_a_q == 8'h30) && (hwdata[5:4] == 2'h0)
    |=> !match_a_pin_oe)
    else $error("pin a driven with mode off");
  a_oe_needs_write: assert property ($changed(match_a_pin_oe) || $changed(match_b_pin_oe)
    |-> wr2_q)
    else $error("pin enable changed without a write");
endmodule

// *** test/ftcc_tb_top.sv ***
`timescale 1ns/10ps
`include "ftcc_regs.svh"

module ftcc_tb_top;
  localparam logic [7:0] gc = 8'h2C;
  localparam logic [7:0] tc = 8'h30;
  localparam logic [7:0] cnt = 8'h34;
  localparam logic [7:0] flg = 8'h44;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic pa;
  logic pa_oe;
  logic pb;
  logic pb_oe;
  logic fck_on = 1'b0;
  logic [1:0] fdiv = 2'h0;
  logic [7:0] rd;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;

  ftcc_top u_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fast_peripheral_clock(fdiv[1]), .match_a_pin(pa), .match_a_pin_oe(pa_oe),
    .match_b_pin(pb), .match_b_pin_oe(pb_oe));

  // Clock; the fast clock stands still whenever it is switched off.
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    if (fck_on) begin
      fdiv <= fdiv + 2'h1;
    end
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single AHB transfer; read data is taken at the edge closing the data phase.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata[7:0];
  endtask

  // Two idle cycles let a counter write land before anything reads it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge mclk);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(what, rd, exp);
  endtask

  task automatic rng(input string what, input logic [7:0] lo, input logic [7:0] hi);
    bus(1'b0, cnt, 8'h00);
    check(what, 32'(rd >= lo && rd <= hi), 32'h1);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 8; i++) rdc("reset value", gc + 8'(4 * i), 8'h00);
    wr(8'h50, 8'hFF);
    rdc("unmapped", 8'h50, 8'h00);
    $display("done reset");
  endtask

  task automatic t_count;
    wr(cnt, 8'h5A);
    rdc("counter rw", cnt, 8'h5A);
    // A read right behind a synchronous counter write still sees the old count.
    bus(1'b1, cnt, 8'h33);
    rdc("write not landed", cnt, 8'h5A);
    rdc("write landed", cnt, 8'h33);
    wr(cnt, 8'hFE);
    wr(tc, 8'h01);
    repeat (10) @(posedge mclk);
    wr(tc, 8'h00);
    rng("wrapped", 8'h00, 8'h14);
    rdc("flags on wrap", flg, 8'h64);
    wr(flg, 8'h64);
    rdc("flags cleared", flg, 8'h00);
    $display("done count");
  endtask

  // Codes 0 to 8 and 15 each run a window scaled to give a count in a known range.
  task automatic t_prescale;
    int w;
    logic [3:0] code;
    for (int n = 0; n <= 9; n++) begin
      code = (n == 9) ? 4'hF : 4'(n);
      w = (n == 9) ? 32768 : ((n == 0) ? 100 : (64 << (n - 1)));
      wr(gc, 8'h02);
      wr(cnt, 8'h00);
      wr(tc, {4'h0, code});
      repeat (w) @(posedge mclk);
      wr(tc, 8'h00);
      if (n == 0) rng("stopped", 8'h00, 8'h00);
      else if (n == 9) rng("divide max", 8'h01, 8'h04);
      else rng("divided count", 8'd63, 8'd72);
    end
    rdc("prescaler bit", gc, 8'h00);
    $display("done prescale");
  endtask

  task automatic t_match;
    logic [1:0] m[4] = '{2'h1, 2'h2, 2'h3, 2'h1};
    logic e[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(8'h48, 8'h03);
    wr(8'h38, 8'h10);
    // A top value inside the counted range shows that clearing stays off.
    wr(8'h40, 8'h14);
    wr(tc, 8'h10);
    wr(cnt, 8'h10);
    rdc("no match on write", flg, 8'h00);
    check("oe a", pa_oe, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(cnt, 8'h0C);
      wr(tc, {2'h0, m[i], 4'h1});
      repeat (12) @(posedge mclk);
      wr(tc, 8'h00);
      check("pin a", pa, e[i]);
      rng("past top", 8'h15, 8'hFF);
      rdc("flag a", flg, 8'h40);
      wr(flg, 8'h40);
    end
    check("oe a off", pa_oe, 1'b0);
    $display("done match");
  endtask

  task automatic t_top;
    logic [7:0] c[3] = '{8'h81, 8'h41, 8'h01};
    logic [7:0] g[3] = '{8'h00, 8'h00, 8'h40};
    wr(8'h40, 8'h20);
    for (int i = 0; i < 3; i++) begin
      wr(gc, g[i]);
      wr(cnt, 8'h00);
      wr(flg, 8'h64);
      wr(tc, c[i]);
      repeat (100) @(posedge mclk);
      wr(tc, c[i] & 8'hF0);
      rng("bounded by top", 8'h00, 8'h20);
      bus(1'b0, flg, 8'h00);
      check("overflow", rd[2], 32'(i != 0));
    end
    wr(gc, 8'h00);
    wr(tc, 8'h00);
    $display("done top");
  endtask

  task automatic t_force;
    logic [7:0] v[4] = '{8'h38, 8'h28, 8'h18, 8'h18};
    logic e[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(tc, 8'h30);
    wr(flg, 8'h64);
    wr(gc, 8'h04);
    check("force a", pa, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(gc, v[i]);
      check("force b", pb, e[i]);
    end
    check("oe b", pb_oe, 1'b1);
    rdc("no flag", flg, 8'h00);
    rdc("force reads zero", gc, 8'h10);
    wr(gc, 8'h58);
    check("force b in pwm", pb, 1'b0);
    wr(gc, 8'h00);
    $display("done force");
  endtask

  // One fast clock rising edge every four cycles, idle means no count.
  task automatic t_fast;
    wr(tc, 8'h00);
    wr(8'h48, 8'h07);
    // In asynchronous clocking a counter write lands within one cycle.
    bus(1'b1, cnt, 8'h44);
    rdc("async write", cnt, 8'h44);
    for (int on = 0; on < 2; on++) begin
      wr(cnt, 8'h00);
      @(posedge mclk);
      fck_on <= on[0];
      wr(tc, 8'h01);
      repeat (200) @(posedge mclk);
      wr(tc, 8'h00);
      fck_on <= 1'b0;
      if (on == 0) rng("fast idle", 8'h00, 8'h00);
      else rng("fast count", 8'd48, 8'd56);
    end
    $display("done fast");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_count();
    t_prescale();
    t_match();
    t_top();
    t_force();
    t_fast();
    stop_test();
  end
endmodule

bind ftcc_top ftcc_properties u_props (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .fast_peripheral_clock(fast_peripheral_clock), .match_a_pin(match_a_pin),
  .match_a_pin_oe(match_a_pin_oe), .match_b_pin(match_b_pin),
  .match_b_pin_oe(match_b_pin_oe));
